/* wes_wake_event_status_logic.sv */
`timescale 1ns/100ps

module wes_wake_event_status_logic #(
  parameter int ADDR_WIDTH = 16
) (
  // Clock and standby power-on reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Runtime register port
  input wire logic [ADDR_WIDTH-1:0] runtime_block_base,
  input wire logic [ADDR_WIDTH-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wr_data,
  output logic [7:0] io_rd_data,
  // Per-source enables held elsewhere
  input wire logic [7:0] source_enable,
  // Wake sources: one-cycle event pulses, except the infrared receive level, whose changes count as events
  input wire logic hardware_monitor_wake,
  input wire logic ring_indicate_two_wake,
  input wire logic ring_indicate_one_wake,
  input wire logic keyboard_wake,
  input wire logic mouse_wake,
  input wire logic infrared_receive_input,
  // Wake pin toward the system, active low
  output logic wake_output_pin_b
);

  initial
  begin
    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32)
      $error("wes: ADDR_WIDTH must be 8 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_reg;
  logic rst_sync_b;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_b <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr,
                               input logic [ADDR_WIDTH-1:0] base,
                               input logic [7:0] off);
    logic [ADDR_WIDTH-1:0] target;
    target = base + ADDR_WIDTH'(off);
    return addr == target;
  endfunction

  wire sel_status = hit(io_addr, runtime_block_base, wes_pkg::OFF_PIN_STATUS);
  wire sel_enable = hit(io_addr, runtime_block_base, wes_pkg::OFF_PIN_ENABLE);
  wire sel_source = hit(io_addr, runtime_block_base, wes_pkg::OFF_SOURCE_STATUS_ONE);

  ////////////////////////////////////////////////////////////////////////////
  // Wake events

  logic infrared_change;

  wes_edge_detect #(
    .WIDTH(1)
  ) u_infrared_edge (
    .ref_clk(ref_clk),
    .rst_sync_b(rst_sync_b),
    .level_in(infrared_receive_input),
    .change_pulse(infrared_change)
  );

  logic [7:0] event_vec;

  always_comb
  begin
    event_vec = 8'h00;
    event_vec[wes_pkg::HARDWARE_MONITOR_WAKE_BIT] = hardware_monitor_wake;
    event_vec[wes_pkg::RING_TWO_BIT] = ring_indicate_two_wake;
    event_vec[wes_pkg::RING_ONE_BIT] = ring_indicate_one_wake;
    event_vec[wes_pkg::KEYBOARD_BIT] = keyboard_wake;
    event_vec[wes_pkg::MOUSE_BIT] = mouse_wake;
    event_vec[wes_pkg::INFRARED_BIT] = infrared_change;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic flag_reg;
  logic flag_next;
  logic gate_reg;
  logic gate_next;
  logic [7:0] source_reg;
  logic [7:0] source_next;
  logic [7:0] rd_data_next;
  logic wake_next;

  wire status_w1c = io_wr && sel_status && io_wr_data[wes_pkg::AGGREGATE_WAKE_FLAG_BIT];
  wire [7:0] source_clr = (io_wr && sel_source) ? io_wr_data : 8'h00;
  wire enabled_event = |(event_vec & source_enable);

  // Set wins over a same-cycle clear
  assign flag_next = enabled_event | (flag_reg & ~status_w1c);
  assign gate_next = (io_wr && sel_enable) ? io_wr_data[wes_pkg::GLOBAL_WAKE_GATE_BIT]
                                           : gate_reg;
  assign source_next = (event_vec | (source_reg & ~source_clr))
                       & wes_pkg::SOURCE_STATUS_MASK;

  // Output asserts while gated, flagged and an enabled status is latched
  assign wake_next = gate_next & flag_next & (|(source_next & source_enable));

  assign rd_data_next = sel_status ? {7'h00, flag_reg} :
                        sel_enable ? {7'h00, gate_reg} :
                        sel_source ? source_reg :
                        wes_pkg::UNMAPPED_READ;

  // Only the standby reset resets these
  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      flag_reg <= wes_pkg::RST_PIN_STATUS[0];
      gate_reg <= wes_pkg::RST_PIN_ENABLE[0];
      source_reg <= wes_pkg::RST_SOURCE_STATUS_ONE;
      io_rd_data <= wes_pkg::UNMAPPED_READ;
      wake_output_pin_b <= 1'b1;
    end
    else
    begin
      flag_reg <= flag_next;
      gate_reg <= gate_next;
      source_reg <= source_next;
      if (io_rd)
        io_rd_data <= rd_data_next;
      wake_output_pin_b <= ~wake_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_flag_clear_write;
    io_wr && sel_status && io_wr_data[0] && !enabled_event;
  endsequence

  property p_flag_sets;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    enabled_event |=> flag_reg;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag missed event");

  property p_flag_clears;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    s_flag_clear_write |=> !flag_reg ##0 wake_output_pin_b;
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("flag not cleared");

  property p_zero_write_keeps;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    (io_wr && sel_source && io_wr_data == 8'h00) |=>
      source_reg == ($past(source_reg) | $past(event_vec));
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write changed");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    (io_rd && sel_status) |=> io_rd_data[7:1] == 7'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_gate_write;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    (io_wr && sel_enable) |=> gate_reg == $past(io_wr_data[0]);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gate write lost");

  property p_source_latch;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    (hardware_monitor_wake && !(io_wr && sel_source)) |=> source_reg[0] [*2] or
      (source_reg[0] ##1 (!source_reg[0] && $past(io_wr && sel_source)));
  endproperty
  a_source_latch: assert property (p_source_latch) else $error("monitor not latched");

  property p_infrared;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    (infrared_change) |=> source_reg[6];
  endproperty
  a_infrared: assert property (p_infrared) else $error("infrared not latched");

  property p_output_cause;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    !wake_output_pin_b |-> gate_reg && flag_reg && (|(source_reg & $past(source_enable)));
  endproperty
  a_output_cause: assert property (p_output_cause) else $error("wake without cause");

  property p_output_asserts;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    (gate_reg && flag_reg && (|(source_reg & source_enable)) && !io_wr) |=> !wake_output_pin_b;
  endproperty
  a_output_asserts: assert property (p_output_asserts) else $error("wake not driven");

  property p_reserved_source;
    @(posedge ref_clk) disable iff (!rst_sync_b)
    source_reg[7] == 1'b0 && source_reg[5] == 1'b0;
  endproperty
  a_reserved_source: assert property (p_reserved_source) else $error("reserved source set");

endmodule

/* wes_pkg.sv */
package wes_pkg;

  // Register offsets from the runtime block base
  localparam logic [7:0] OFF_PIN_STATUS = 8'h00;
  localparam logic [7:0] OFF_PIN_ENABLE = 8'h02;
  localparam logic [7:0] OFF_SOURCE_STATUS_ONE = 8'h04;

  // Reset values on standby power-on reset
  localparam logic [7:0] RST_PIN_STATUS = 8'h00;
  localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
  localparam logic [7:0] RST_SOURCE_STATUS_ONE = 8'h00;

  // Field positions
  localparam int AGGREGATE_WAKE_FLAG_BIT = 0;
  localparam int GLOBAL_WAKE_GATE_BIT = 0;
  localparam int HARDWARE_MONITOR_WAKE_BIT = 0;
  localparam int RING_TWO_BIT = 1;
  localparam int RING_ONE_BIT = 2;
  localparam int KEYBOARD_BIT = 3;
  localparam int MOUSE_BIT = 4;
  localparam int INFRARED_BIT = 6;

  // Implemented bits of the source status register
  localparam logic [7:0] SOURCE_STATUS_MASK = 8'h5F;

  // Unmapped reads answer this value
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

/* wes_edge_detect.sv */
`timescale 1ns/100ps

module wes_edge_detect #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_sync_b,
  // Sampled level and change pulse
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] change_pulse
);

  initial
  begin
    if (WIDTH < 1)
      $error("wes_edge_detect: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] prev_reg;
  logic primed_reg;

  // Previous level; first cycle after reset only primes the history
  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      prev_reg <= '0;
      primed_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= level_in;
      primed_reg <= 1'b1;
    end
  end

  assign change_pulse = (level_in ^ prev_reg) & {WIDTH{primed_reg}};

endmodule

/* wes_wake_receiver.sv */
`timescale 1ns/100ps
module wes_wake_receiver (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Wake pin from the block
  input wire logic wake_output_pin_b,
  // Count of wake requests seen
  output logic [7:0] wake_count
);
  logic pin_last_reg;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_last_reg <= 1'b1;
      wake_count <= 8'h00;
    end
    else
    begin
      pin_last_reg <= wake_output_pin_b;
      if (pin_last_reg && !wake_output_pin_b)
        wake_count <= wake_count + 8'h01;
    end
  end
endmodule

/* wake_event_status_logic_tb.sv */
`timescale 1ns/100ps
module wake_event_status_logic_tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] base = 16'h0A00;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wr_data = 8'h00;
  logic [7:0] io_rd_data;
  logic [7:0] source_enable = 8'h00;
  logic [4:0] wk = 5'h00;
  logic ir = 1'b0;
  logic pin_b;
  logic [7:0] wake_count;
  int num_errors = 0;
  int comparisons = 0;
  wes_wake_event_status_logic #(.ADDR_WIDTH(16)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .runtime_block_base(base), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wr_data(io_wr_data), .io_rd_data(io_rd_data),
    .source_enable(source_enable), .hardware_monitor_wake(wk[0]),
    .ring_indicate_two_wake(wk[1]), .ring_indicate_one_wake(wk[2]),
    .keyboard_wake(wk[3]), .mouse_wake(wk[4]), .infrared_receive_input(ir),
    .wake_output_pin_b(pin_b)
  );
  wes_wake_receiver rx (
    .ref_clk(ref_clk), .rst_b(rst_b), .wake_output_pin_b(pin_b), .wake_count(wake_count)
  );
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    idle(1);
    io_addr = base + {8'h00, off};
    io_wr_data = d;
    io_wr = 1'b1;
    idle(1);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] off, input logic [7:0] exp);
    idle(1);
    io_addr = base + {8'h00, off};
    io_rd = 1'b1;
    idle(1);
    io_rd = 1'b0;
    chk($sformatf("register %h", off), exp, io_rd_data);
  endtask
  task automatic pulse(input int i);
    idle(1);
    wk[i] = 1'b1;
    idle(1);
    wk = 5'h00;
  endtask
  task automatic do_reset();
    idle(1);
    rst_b = 1'b0;
    idle(3);
    rst_b = 1'b1;
    idle(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h04, 8'h00);
    chk("wake pin", 8'h01, {7'h00, pin_b});
    wr(8'h02, 8'h01);
    rd(8'h02, 8'h01);
    for (int i = 0; i < 5; i++) pulse(i);
    rd(8'h04, 8'h1F);
    rd(8'h00, 8'h00);
    chk("wake pin", 8'h01, {7'h00, pin_b});
    idle(1);
    ir = 1'b1;
    rd(8'h04, 8'h5F);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h5F);
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h5E);
    wr(8'h06, 8'hFF);
    rd(8'h04, 8'h5E);
    rd(8'h01, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h00);
    wr(8'h02, 8'h00);
    source_enable = 8'h08;
    pulse(3);
    rd(8'h00, 8'h01);
    chk("wake pin", 8'h01, {7'h00, pin_b});
    wr(8'h02, 8'h01);
    idle(1);
    chk("wake pin", 8'h00, {7'h00, pin_b});
    wr(8'h00, 8'h00);
    idle(1);
    chk("wake pin", 8'h00, {7'h00, pin_b});
    wr(8'h00, 8'h01);
    idle(1);
    chk("wake pin", 8'h01, {7'h00, pin_b});
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h08);
    wr(8'h06, 8'h00);
    chk("read hold", 8'h08, io_rd_data);
    chk("wake count", 8'h01, wake_count);
    do_reset();
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h04, 8'h00);
    ir = 1'b0;
    rd(8'h04, 8'h40);
    end_of_test();
  end
  initial
  begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule
